// ### logic/pctm_manager.sv
// Power-condition manager: timers, subcommand decode, transitions.
// Assumes command strobes are one-cycle pulses synchronous to sys_clk.
`timescale 1ns/1ps
module pctm_manager (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic tick,
    input wire logic power_cycle,
    input wire logic dev_reset,
    input wire logic feat_req,
    input wire logic [7:0] feat_code,
    input wire pctm_pkg::pctm_cmd_type cmd,
    input wire logic cmd_accept,
    input wire logic cmd_needs_active,
    input wire logic cmd_complete,
    input wire logic advanced_power_mgmt_ok,
    input wire logic ident_w120_b7,
    input wire logic background_busy,
    input wire logic write_cache_en,
    input wire logic flush_done,
    output pctm_pkg::pctm_resp_type resp,
    output logic flush_req,
    output logic media_blocked,
    output logic extended_power_states,
    output pctm_pkg::pctm_mgmt_type mgmt_state,
    output logic [2:0] cond_idx
);
    // ==========================================================
    // Settings storage
    // ==========================================================
    logic [pctm_pkg::TW-1:0] cur_timer [pctm_pkg::NUM_COND];
    logic [pctm_pkg::TW-1:0] saved_timer [pctm_pkg::NUM_COND];
    logic [pctm_pkg::NUM_COND-1:0] cur_en;
    logic [pctm_pkg::NUM_COND-1:0] saved_en;
    logic [pctm_pkg::NUM_COND-1:0] running;
    logic [pctm_pkg::NUM_COND-1:0] expired;
    logic in_active;
    logic [2:0] target;
    logic restart_pend;
    pctm_pkg::pctm_fsm_type fsm;

    // Map identifier to index; IDX_NONE for reserved or all
    function automatic logic [2:0] id_to_idx(input logic [7:0] id);
        unique case (id)
            pctm_pkg::ID_IDLE_A: id_to_idx = pctm_pkg::IDX_IDLE_A;
            pctm_pkg::ID_IDLE_B: id_to_idx = pctm_pkg::IDX_IDLE_B;
            pctm_pkg::ID_IDLE_C: id_to_idx = pctm_pkg::IDX_IDLE_C;
            pctm_pkg::ID_STANDBY_Y: id_to_idx = pctm_pkg::IDX_STANDBY_Y;
            pctm_pkg::ID_STANDBY_Z: id_to_idx = pctm_pkg::IDX_STANDBY_Z;
            default: id_to_idx = pctm_pkg::IDX_NONE;
        endcase
    endfunction

    // ==========================================================
    // Request decode
    // ==========================================================
    wire logic is_feat = feat_req && (feat_code == pctm_pkg::FEAT_EXT_POWER);
    wire logic [2:0] req_idx = id_to_idx(cmd.cond_id);
    wire logic id_all = (cmd.cond_id == pctm_pkg::ID_ALL);
    wire logic id_ok = (req_idx != pctm_pkg::IDX_NONE) || id_all;
    wire logic sub_restore = (cmd.sub == pctm_pkg::SUB_RESTORE);
    wire logic sub_goto = (cmd.sub == pctm_pkg::SUB_GOTO);
    wire logic sub_timer = (cmd.sub == pctm_pkg::SUB_SET_TIMER);
    wire logic sub_state = (cmd.sub == pctm_pkg::SUB_SET_STATE);
    wire logic sub_enable = (cmd.sub == pctm_pkg::SUB_ENABLE);
    wire logic sub_disable = (cmd.sub == pctm_pkg::SUB_DISABLE);
    wire logic needs_id = sub_restore || sub_timer || sub_state;
    wire logic sub_known = sub_restore || sub_goto || sub_timer || sub_state
        || sub_enable || sub_disable;
    // Go-to takes one concrete condition only
    wire logic goto_ok = sub_goto && (req_idx != pctm_pkg::IDX_NONE);
    wire logic bad_req = !sub_known || (needs_id && !id_ok)
        || (sub_goto && !goto_ok);
    wire logic abort_req = is_feat && (bad_req
        || (!extended_power_states && !sub_enable));
    wire logic ok_req = is_feat && !abort_req;
    wire logic do_enable = (ok_req && sub_enable) || power_cycle;
    wire logic adv_pm_kill = advanced_power_mgmt_ok && ident_w120_b7;
    wire logic do_disable = (ok_req && sub_disable) || adv_pm_kill;
    wire logic stop_all = do_enable || dev_reset
        || (cmd_accept && cmd_needs_active) || do_disable;
    wire logic reload = cmd_complete || restart_pend;
    wire logic timers_live = extended_power_states && !stop_all;

    // Stop wins over load in a timer, so the restart comes one cycle after the stop
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            restart_pend <= 1'b0;
        end else if (ce) begin
            restart_pend <= do_enable || dev_reset;
        end
    end

    // ==========================================================
    // Per-condition timers
    // ==========================================================
    genvar gi;
    generate
        for (gi = 0; gi < pctm_pkg::NUM_COND; gi++) begin : g_timer
            pctm_timer u_timer (
                .sys_clk(sys_clk),
                .rst(rst),
                .ce(ce),
                .tick(tick),
                .load(reload && timers_live),
                .stop(stop_all || !extended_power_states),
                .pause(background_busy),
                .enabled(cur_en[gi]),
                .setting(cur_timer[gi]),
                .running(running[gi]),
                .expired(expired[gi])
            );
        end
    endgenerate

    // ==========================================================
    // Transition choice
    // ==========================================================
    // Highest index wins, which is the lowest-power expiry
    always_comb begin
        target = pctm_pkg::IDX_NONE;
        for (int i = 0; i < pctm_pkg::NUM_COND; i++) begin
            // A timer zeroed while it ran must not pull the device in
            if (expired[i] && cur_en[i]
                && (cur_timer[i] != pctm_pkg::TIMER_ZERO)) begin
                target = 3'(i);
            end
        end
    end

    // Active counts as above every condition
    wire logic lower_power = (target != pctm_pkg::IDX_NONE)
        && (in_active || (target > cond_idx));
    wire logic blocks_media_t = (target >= pctm_pkg::IDX_FIRST_STANDBY);
    wire logic goto_now = ok_req && goto_ok;

    // Standby conditions stop the spindle and block the media
    assign media_blocked = !in_active && (cond_idx >= pctm_pkg::IDX_FIRST_STANDBY);
    assign mgmt_state = in_active ? pctm_pkg::PCTM_ACTIVE
        : media_blocked ? pctm_pkg::PCTM_STANDBY : pctm_pkg::PCTM_IDLE;
    assign flush_req = (fsm == pctm_pkg::PCTM_FLUSH);

    logic [2:0] pend;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            fsm <= pctm_pkg::PCTM_RUN;
            pend <= pctm_pkg::IDX_NONE;
            in_active <= 1'b1;
            cond_idx <= pctm_pkg::IDX_IDLE_A;
        end else if (ce) begin
            unique case (fsm)
                pctm_pkg::PCTM_RUN: begin
                    if (cmd_accept && cmd_needs_active) begin
                        in_active <= 1'b1;
                    end else if (goto_now || (lower_power && timers_live)) begin
                        pend <= goto_now ? req_idx : target;
                        if (write_cache_en && (goto_now ? (req_idx >=
                            pctm_pkg::IDX_FIRST_STANDBY) : blocks_media_t)) begin
                            fsm <= pctm_pkg::PCTM_FLUSH;
                        end else begin
                            fsm <= pctm_pkg::PCTM_ENTER;
                        end
                    end
                end
                pctm_pkg::PCTM_FLUSH: begin
                    if (flush_done) begin
                        fsm <= pctm_pkg::PCTM_ENTER;
                    end
                end
                pctm_pkg::PCTM_ENTER: begin
                    cond_idx <= pend;
                    in_active <= 1'b0;
                    fsm <= pctm_pkg::PCTM_RUN;
                end
                default: fsm <= pctm_pkg::PCTM_RUN;
            endcase
        end
    end

    // ==========================================================
    // Settings update
    // ==========================================================
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            extended_power_states <= 1'b0;
            cur_en <= pctm_pkg::DEFAULT_ENABLE;
            saved_en <= pctm_pkg::DEFAULT_ENABLE;
            resp <= '0;
            for (int i = 0; i < pctm_pkg::NUM_COND; i++) begin
                cur_timer[i] <= pctm_pkg::DEFAULT_TIMER[i];
                saved_timer[i] <= pctm_pkg::DEFAULT_TIMER[i];
            end
        end else if (ce) begin
            resp.done <= is_feat;
            resp.aborted <= abort_req;
            if (do_disable) begin
                extended_power_states <= 1'b0;
            end else if (ok_req && sub_enable) begin
                extended_power_states <= 1'b1;
            end
            if (do_enable) begin
                cur_en <= saved_en;
                for (int i = 0; i < pctm_pkg::NUM_COND; i++) begin
                    cur_timer[i] <= saved_timer[i];
                end
            end else if (ok_req && needs_id) begin
                for (int i = 0; i < pctm_pkg::NUM_COND; i++) begin
                    if (id_all || (req_idx == 3'(i))) begin
                        if (sub_restore) begin
                            // Save flag picks saved or default source
                            cur_timer[i] <= cmd.save ? pctm_pkg::DEFAULT_TIMER[i]
                                : saved_timer[i];
                            cur_en[i] <= cmd.save ? pctm_pkg::DEFAULT_ENABLE[i]
                                : saved_en[i];
                        end else if (sub_timer) begin
                            cur_timer[i] <= cmd.timer;
                            cur_en[i] <= cmd.enable;
                        end else begin
                            cur_en[i] <= cmd.enable;
                        end
                        if (cmd.save && sub_restore) begin
                            saved_timer[i] <= pctm_pkg::DEFAULT_TIMER[i];
                            saved_en[i] <= pctm_pkg::DEFAULT_ENABLE[i];
                        end else if (cmd.save && sub_timer) begin
                            saved_timer[i] <= cmd.timer;
                            saved_en[i] <= cmd.enable;
                        end else if (cmd.save && sub_state) begin
                            saved_en[i] <= cmd.enable;
                        end
                    end
                end
            end
        end
    end

    // ==========================================================
    // Checks
    // ==========================================================
    chk_abort_when_off: assert property (@(posedge sys_clk) disable iff (rst)
        ce && is_feat && !extended_power_states && !sub_enable |=> resp.aborted)
        else $error("subcommand not aborted while feature off");
    chk_reserved_sub_abort: assert property (@(posedge sys_clk) disable iff (rst)
        ce && is_feat && !sub_known |=> resp.aborted)
        else $error("reserved subcommand accepted");
    chk_reserved_id_keeps: assert property (@(posedge sys_clk) disable iff (rst)
        ce && is_feat && sub_timer && !id_ok && !power_cycle
        |=> cur_en == $past(cur_en))
        else $error("reserved id changed settings");
    chk_adv_pm_disables: assert property (@(posedge sys_clk) disable iff (rst)
        ce && advanced_power_mgmt_ok && ident_w120_b7 |=> !extended_power_states)
        else $error("feature still on after power-management enable");
    chk_flush_first: assert property (@(posedge sys_clk) disable iff (rst)
        ce && fsm == pctm_pkg::PCTM_FLUSH && !flush_done |=> !$changed(cond_idx))
        else $error("condition changed before flush");
    chk_power_cycle_copy: assert property (@(posedge sys_clk) disable iff (rst)
        ce && power_cycle |=> cur_en == $past(saved_en))
        else $error("saved enables not copied");
    chk_only_lower: assert property (@(posedge sys_clk) disable iff (rst)
        ce && fsm == pctm_pkg::PCTM_RUN && !goto_now && !in_active && (expired != '0)
        && !(cmd_accept && cmd_needs_active)
        |=> fsm == pctm_pkg::PCTM_RUN || pend > $past(cond_idx))
        else $error("moved to higher power on expiry");
    chk_active_stops: assert property (@(posedge sys_clk) disable iff (rst)
        ce && cmd_accept && cmd_needs_active |=> running == '0)
        else $error("timers run after active command");
    chk_reset_keeps: assert property (@(posedge sys_clk) disable iff (rst)
        ce && dev_reset && fsm == pctm_pkg::PCTM_RUN && !goto_now && !cmd_accept
        |=> fsm == pctm_pkg::PCTM_RUN && $stable(cond_idx))
        else $error("reset changed condition");
endmodule // pctm_manager

// ### shared/pctm_pkg.sv
// Package for the power-condition timer manager.
// Assumes one clock domain; timer values count in host-supplied ticks.
package pctm_pkg;

    // ==========================================================
    // Feature code and subcommands
    // ==========================================================
    localparam logic [7:0] FEAT_EXT_POWER = 8'h4a;
    localparam logic [3:0] SUB_RESTORE = 4'h0;
    localparam logic [3:0] SUB_GOTO = 4'h1;
    localparam logic [3:0] SUB_SET_TIMER = 4'h2;
    localparam logic [3:0] SUB_SET_STATE = 4'h3;
    localparam logic [3:0] SUB_ENABLE = 4'h4;
    localparam logic [3:0] SUB_DISABLE = 4'h5;

    // ==========================================================
    // Condition identifiers
    // ==========================================================
    localparam logic [7:0] ID_STANDBY_Z = 8'h00;
    localparam logic [7:0] ID_STANDBY_Y = 8'h01;
    localparam logic [7:0] ID_IDLE_A = 8'h81;
    localparam logic [7:0] ID_IDLE_B = 8'h82;
    localparam logic [7:0] ID_IDLE_C = 8'h83;
    localparam logic [7:0] ID_ALL = 8'hff;

    // Condition index: higher index means lower power
    localparam int NUM_COND = 5;
    localparam int TW = 32;
    localparam logic [2:0] IDX_IDLE_A = 3'h0;
    localparam logic [2:0] IDX_IDLE_B = 3'h1;
    localparam logic [2:0] IDX_IDLE_C = 3'h2;
    localparam logic [2:0] IDX_STANDBY_Y = 3'h3;
    localparam logic [2:0] IDX_STANDBY_Z = 3'h4;
    localparam logic [2:0] IDX_NONE = 3'h7;
    localparam logic [2:0] IDX_FIRST_STANDBY = 3'h3;
    localparam logic [TW-1:0] TIMER_ZERO = 32'h0000_0000;
    localparam logic [TW-1:0] TIMER_ONE = 32'h0000_0001;

    // Default timer settings, read-only
    localparam logic [TW-1:0] DEFAULT_TIMER [NUM_COND] = '{
        32'h0000_0064, 32'h0000_01f4, 32'h0000_0bb8, 32'h0000_1770, 32'h0000_2ee0};
    localparam logic [NUM_COND-1:0] DEFAULT_ENABLE = 5'h1f;

    // Management states
    typedef enum logic [1:0] {
        PCTM_ACTIVE = 2'h0,
        PCTM_IDLE = 2'h1,
        PCTM_STANDBY = 2'h3
    } pctm_mgmt_type;

    // Control state machine, Gray from RUN through FLUSH to ENTER
    typedef enum logic [1:0] {
        PCTM_RUN = 2'h0,
        PCTM_FLUSH = 2'h1,
        PCTM_ENTER = 2'h3
    } pctm_fsm_type;

    typedef struct packed {
        logic [3:0] sub;
        logic [7:0] cond_id;
        logic [TW-1:0] timer;
        logic enable;
        logic save;
    } pctm_cmd_type;

    typedef struct packed {
        logic done;
        logic aborted;
    } pctm_resp_type;

endpackage

// ### logic/pctm_timer.sv
// One countdown timer for a single power condition.
// Assumes tick is a one-cycle pulse in the sys_clk domain.
`timescale 1ns/1ps
module pctm_timer (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic tick,
    input wire logic load,
    input wire logic stop,
    input wire logic pause,
    input wire logic enabled,
    input wire logic [pctm_pkg::TW-1:0] setting,
    output logic running,
    output logic expired
);
    logic [pctm_pkg::TW-1:0] count;

    // ==========================================================
    // Countdown
    // ==========================================================
    // A zero setting leaves the timer stopped
    wire logic start_ok = enabled && (setting != pctm_pkg::TIMER_ZERO);
    wire logic at_one = (count == pctm_pkg::TIMER_ONE);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            count <= pctm_pkg::TIMER_ZERO;
            running <= 1'b0;
            expired <= 1'b0;
        end else if (ce) begin
            expired <= 1'b0;
            if (stop) begin
                running <= 1'b0;
            end else if (load && !running) begin
                count <= setting;
                running <= start_ok;
            end else if (running && tick && !pause) begin
                count <= count - pctm_pkg::TIMER_ONE;
                if (at_one) begin
                    running <= 1'b0;
                    expired <= 1'b1;
                end
            end
        end
    end

    chk_zero_never_runs: assert property (@(posedge sys_clk) disable iff (rst)
        ce && load && !stop && !running && (setting == pctm_pkg::TIMER_ZERO)
        |=> !running)
        else $error("zero timer started");
    chk_pause_holds_count: assert property (@(posedge sys_clk) disable iff (rst)
        ce && pause && !stop && !load |=> count == $past(count))
        else $error("paused timer moved");
endmodule // pctm_timer

// ### tb/pctm_flush_model.sv
// Write-cache and media side model: answers each flush request of the manager.
// Assumes flush_req stays high until flush_done has been seen, as the manager promises.
`timescale 1ns/1ps
module pctm_flush_model (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic flush_req,
    input wire logic [7:0] delay,
    output logic flush_done
);
    // ==========================================================
    // Flush responder
    // ==========================================================
    logic [7:0] count;

    // Count clears whenever the request drops, so every flush waits the full delay
    always_ff @(posedge sys_clk) begin
        if (rst || !flush_req) begin
            count <= 8'h00;
            flush_done <= 1'b0;
        end else begin
            count <= count + 8'h01;
            flush_done <= (count == delay);
        end
    end
endmodule // pctm_flush_model

// ### tb/pctm_manager_test.sv
// Self-checking bench for the power-condition manager.
// Assumes the flush model on the cache side and short timer values set by subcommand.
`timescale 1ns/1ps
module pctm_manager_test;
    // ==========================================================
    // Signals
    // ==========================================================
    logic sys_clk, rst, ce, tick, power_cycle, dev_reset, feat_req;
    logic [7:0] feat_code, req_code;
    pctm_pkg::pctm_cmd_type cmd;
    logic cmd_accept, cmd_needs_active, cmd_complete, advanced_power_mgmt_ok, ident_w120_b7;
    logic background_busy, write_cache_en, flush_done, flush_req, media_blocked;
    logic extended_power_states;
    pctm_pkg::pctm_resp_type resp;
    pctm_pkg::pctm_mgmt_type mgmt_state;
    logic [2:0] cond_idx;
    int failures = 0;
    int tests_run = 0;
    int cycles = 0;
    // Whole run needs well under a thousand cycles
    localparam int LIMIT = 5000;

    pctm_manager uut (.sys_clk(sys_clk), .rst(rst), .ce(ce), .tick(tick),
        .power_cycle(power_cycle), .dev_reset(dev_reset), .feat_req(feat_req),
        .feat_code(feat_code), .cmd(cmd), .cmd_accept(cmd_accept),
        .cmd_needs_active(cmd_needs_active), .cmd_complete(cmd_complete),
        .advanced_power_mgmt_ok(advanced_power_mgmt_ok), .ident_w120_b7(ident_w120_b7),
        .background_busy(background_busy), .write_cache_en(write_cache_en),
        .flush_done(flush_done), .resp(resp), .flush_req(flush_req),
        .media_blocked(media_blocked), .extended_power_states(extended_power_states),
        .mgmt_state(mgmt_state), .cond_idx(cond_idx));

    pctm_flush_model flush_side (.sys_clk(sys_clk), .rst(rst), .flush_req(flush_req),
        .delay(8'h08), .flush_done(flush_done));

    always #2 sys_clk = ~sys_clk;

    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            failures++;
            end_of_test();
        end
    end

    // ==========================================================
    // Compare and access tasks
    // ==========================================================
    task automatic cmp_bit(input string name, input logic exp, input logic got);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic cmp_idx(input string name, input logic [2:0] exp, input logic [2:0] got);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic cmp_mgmt(input pctm_pkg::pctm_mgmt_type exp);
        tests_run++;
        if (mgmt_state !== exp) begin
            failures++;
            $display("[FAIL] mgmt_state expected %h seen %h", exp, mgmt_state);
        end
    endtask

    // One subcommand; answer is registered one cycle after the request
    task automatic feat(input logic [3:0] sub, input logic [7:0] id, input logic [31:0] tmr,
        input logic en, input logic sv, input logic ab);
        @(posedge sys_clk);
        feat_req <= 1'b1;
        feat_code <= req_code;
        cmd <= {sub, id, tmr, en, sv};
        @(posedge sys_clk);
        feat_req <= 1'b0;
        #1;
        if (req_code === pctm_pkg::FEAT_EXT_POWER) begin
            cmp_bit("resp.done", 1'b1, resp.done);
            cmp_bit("resp.aborted", ab, resp.aborted);
        end
    endtask

    // sel: 0 accept, 1 complete, 2 device reset, 3 power cycle, 4 power-management enable
    task automatic pulse(input int sel, input logic na);
        @(posedge sys_clk);
        cmd_needs_active <= na;
        {cmd_accept, cmd_complete, dev_reset, power_cycle, advanced_power_mgmt_ok} <= 5'h10 >> sel;
        @(posedge sys_clk);
        {cmd_accept, cmd_complete, dev_reset, power_cycle, advanced_power_mgmt_ok} <= 5'h00;
    endtask

    task automatic restart();
        pulse(0, 1'b1);
        pulse(1, 1'b0);
    endtask

    task automatic tick_n(input int n);
        repeat (n) begin
            @(posedge sys_clk);
            tick <= 1'b1;
            @(posedge sys_clk);
            tick <= 1'b0;
        end
    endtask

    task automatic settle();
        repeat (6) @(posedge sys_clk);
        #1;
    endtask

    task automatic wait_idx(input logic [2:0] exp);
        for (int i = 0; i < 40 && cond_idx !== exp; i++) begin
            @(posedge sys_clk);
            #1;
        end
        cmp_idx("cond_idx", exp, cond_idx);
    endtask

    task automatic test_done(input string name);
        $display("test %s finished, mismatches so far %0d", name, failures);
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ==========================================================
    // Tests
    // ==========================================================
    initial begin
        {sys_clk, tick, power_cycle, dev_reset, feat_req, cmd} = '0;
        {cmd_accept, cmd_needs_active, cmd_complete, advanced_power_mgmt_ok} = 4'h0;
        {ident_w120_b7, background_busy} = 2'h0;
        rst = 1'b1;
        ce = 1'b1;
        write_cache_en = 1'b1;
        feat_code = 8'h00;
        req_code = pctm_pkg::FEAT_EXT_POWER;
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        #1;
        cmp_bit("extended_power_states", 1'b0, extended_power_states);
        cmp_mgmt(pctm_pkg::PCTM_ACTIVE);
        cmp_idx("cond_idx", pctm_pkg::IDX_IDLE_A, cond_idx);
        cmp_bit("flush_req", 1'b0, flush_req);
        test_done("reset");

        feat(pctm_pkg::SUB_SET_TIMER, pctm_pkg::ID_IDLE_A, 32'h2, 1'b1, 1'b0, 1'b1);
        req_code = 8'h4b;
        feat(pctm_pkg::SUB_ENABLE, pctm_pkg::ID_ALL, 32'h0, 1'b1, 1'b0, 1'b0);
        cmp_bit("extended_power_states", 1'b0, extended_power_states);
        req_code = pctm_pkg::FEAT_EXT_POWER;
        feat(pctm_pkg::SUB_ENABLE, pctm_pkg::ID_ALL, 32'h0, 1'b1, 1'b0, 1'b0);
        cmp_bit("extended_power_states", 1'b1, extended_power_states);
        for (int s = 6; s < 16; s++) begin
            feat(s[3:0], pctm_pkg::ID_IDLE_A, 32'h1, 1'b1, 1'b0, 1'b1);
        end
        feat(pctm_pkg::SUB_SET_TIMER, 8'h02, 32'h1, 1'b1, 1'b0, 1'b1);
        feat(pctm_pkg::SUB_GOTO, pctm_pkg::ID_ALL, 32'h0, 1'b1, 1'b0, 1'b1);
        restart();
        tick_n(3);
        settle();
        cmp_mgmt(pctm_pkg::PCTM_ACTIVE);
        test_done("decode");

        feat(pctm_pkg::SUB_SET_TIMER, pctm_pkg::ID_IDLE_A, 32'h6, 1'b1, 1'b0, 1'b0);
        feat(pctm_pkg::SUB_SET_TIMER, pctm_pkg::ID_IDLE_B, 32'h2, 1'b1, 1'b0, 1'b0);
        feat(pctm_pkg::SUB_SET_TIMER, pctm_pkg::ID_IDLE_C, 32'h2, 1'b1, 1'b0, 1'b0);
        feat(pctm_pkg::SUB_SET_TIMER, pctm_pkg::ID_STANDBY_Y, 32'h4, 1'b1, 1'b0, 1'b0);
        feat(pctm_pkg::SUB_SET_TIMER, pctm_pkg::ID_STANDBY_Z, 32'h0, 1'b1, 1'b0, 1'b0);
        restart();
        tick_n(2);
        wait_idx(pctm_pkg::IDX_IDLE_C);
        cmp_mgmt(pctm_pkg::PCTM_IDLE);
        tick_n(2);
        for (int i = 0; i < 20 && flush_req !== 1'b1; i++) @(posedge sys_clk);
        #1;
        cmp_bit("flush_req", 1'b1, flush_req);
        cmp_idx("cond_idx", pctm_pkg::IDX_IDLE_C, cond_idx);
        cmp_bit("media_blocked", 1'b0, media_blocked);
        wait_idx(pctm_pkg::IDX_STANDBY_Y);
        cmp_bit("media_blocked", 1'b1, media_blocked);
        cmp_mgmt(pctm_pkg::PCTM_STANDBY);
        tick_n(2);
        settle();
        cmp_idx("cond_idx", pctm_pkg::IDX_STANDBY_Y, cond_idx);
        pulse(2, 1'b0);
        settle();
        cmp_idx("cond_idx", pctm_pkg::IDX_STANDBY_Y, cond_idx);
        test_done("expiry");

        pulse(0, 1'b1);
        settle();
        cmp_mgmt(pctm_pkg::PCTM_ACTIVE);
        tick_n(8);
        settle();
        cmp_mgmt(pctm_pkg::PCTM_ACTIVE);
        pulse(1, 1'b0);
        tick_n(1);
        @(posedge sys_clk);
        background_busy <= 1'b1;
        tick_n(4);
        settle();
        cmp_mgmt(pctm_pkg::PCTM_ACTIVE);
        background_busy <= 1'b0;
        tick_n(1);
        wait_idx(pctm_pkg::IDX_IDLE_C);
        pulse(0, 1'b0);
        tick_n(2);
        wait_idx(pctm_pkg::IDX_STANDBY_Y);
        test_done("timers");

        feat(pctm_pkg::SUB_GOTO, pctm_pkg::ID_IDLE_B, 32'h0, 1'b1, 1'b0, 1'b0);
        wait_idx(pctm_pkg::IDX_IDLE_B);
        feat(pctm_pkg::SUB_SET_STATE, pctm_pkg::ID_STANDBY_Y, 32'h0, 1'b0, 1'b0, 1'b0);
        restart();
        tick_n(4);
        settle();
        cmp_idx("cond_idx", pctm_pkg::IDX_IDLE_C, cond_idx);
        feat(pctm_pkg::SUB_RESTORE, pctm_pkg::ID_ALL, 32'h0, 1'b0, 1'b0, 1'b0);
        restart();
        tick_n(6);
        settle();
        cmp_mgmt(pctm_pkg::PCTM_ACTIVE);
        feat(pctm_pkg::SUB_DISABLE, pctm_pkg::ID_ALL, 32'h0, 1'b0, 1'b0, 1'b0);
        cmp_bit("extended_power_states", 1'b0, extended_power_states);
        feat(pctm_pkg::SUB_GOTO, pctm_pkg::ID_IDLE_B, 32'h0, 1'b1, 1'b0, 1'b1);
        feat(pctm_pkg::SUB_ENABLE, pctm_pkg::ID_ALL, 32'h0, 1'b1, 1'b0, 1'b0);
        pulse(4, 1'b0);
        settle();
        cmp_bit("extended_power_states", 1'b1, extended_power_states);
        ident_w120_b7 <= 1'b1;
        pulse(4, 1'b0);
        settle();
        cmp_bit("extended_power_states", 1'b0, extended_power_states);
        test_done("feature");

        feat(pctm_pkg::SUB_ENABLE, pctm_pkg::ID_ALL, 32'h0, 1'b1, 1'b0, 1'b0);
        feat(pctm_pkg::SUB_SET_TIMER, pctm_pkg::ID_IDLE_B, 32'h3, 1'b1, 1'b1, 1'b0);
        feat(pctm_pkg::SUB_SET_TIMER, pctm_pkg::ID_IDLE_C, 32'h2, 1'b1, 1'b0, 1'b0);
        pulse(3, 1'b0);
        settle();
        cmp_bit("extended_power_states", 1'b1, extended_power_states);
        restart();
        tick_n(3);
        wait_idx(pctm_pkg::IDX_IDLE_B);
        test_done("power");
        end_of_test();
    end
endmodule // pctm_manager_test
